// ---- hdl/tcw_pkg.sv ----
package tcw_pkg;

  // ==========================================================================
  // counter limits and reset values
  localparam logic [7:0] TCW_BOTTOM     = 8'h00;
  localparam logic [7:0] TCW_MAX        = 8'hff;
  localparam logic [7:0] TCW_CNT_RESET  = 8'h00;
  localparam logic [7:0] TCW_CMP_RESET  = 8'h00;

  // ==========================================================================
  // waveform modes
  localparam logic [2:0] TCW_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TCW_WGM_PC_FF  = 3'h1;
  localparam logic [2:0] TCW_WGM_CLRM   = 3'h2;
  localparam logic [2:0] TCW_WGM_FP_FF  = 3'h3;
  localparam logic [2:0] TCW_WGM_PC_OCA = 3'h5;
  localparam logic [2:0] TCW_WGM_FP_OCA = 3'h7;

  // ==========================================================================
  // compare output actions in non-pwm modes
  localparam logic [1:0] TCW_COM_NONE   = 2'h0;
  localparam logic [1:0] TCW_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TCW_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TCW_COM_SET    = 2'h3;

  // ==========================================================================
  // prescaler selection
  localparam logic [2:0] TCW_CS_STOP    = 3'h0;
  localparam logic [2:0] TCW_CS_DIV1    = 3'h1;
  localparam logic [2:0] TCW_CS_DIV8    = 3'h2;
  localparam logic [2:0] TCW_CS_DIV32   = 3'h3;
  localparam logic [2:0] TCW_CS_DIV64   = 3'h4;
  localparam logic [2:0] TCW_CS_DIV128  = 3'h5;
  localparam logic [2:0] TCW_CS_DIV256  = 3'h6;
  localparam logic [2:0] TCW_CS_DIV1024 = 3'h7;
  localparam int         TCW_PRE_W      = 10;

endpackage : tcw_pkg

// ---- hdl/tcw_prescaler.sv ----
`timescale 1ns/1ps

// ============================================================================
// prescaler: free 10-bit divider, one-cycle tick per selected period
module tcw_prescaler
  import tcw_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] clock_select,
  output logic            timer_tick
);

  logic [TCW_PRE_W-1:0] div_r;
  logic [TCW_PRE_W-1:0] div_nxt;
  logic                 tick_sel;

  assign div_nxt = div_r + 10'h001;

  // tick when the low bits of the divider are all ones
  always_comb begin
    case (clock_select)
      TCW_CS_DIV1:    tick_sel = 1'b1;
      TCW_CS_DIV8:    tick_sel = &div_r[2:0];
      TCW_CS_DIV32:   tick_sel = &div_r[4:0];
      TCW_CS_DIV64:   tick_sel = &div_r[5:0];
      TCW_CS_DIV128:  tick_sel = &div_r[6:0];
      TCW_CS_DIV256:  tick_sel = &div_r[7:0];
      TCW_CS_DIV1024: tick_sel = &div_r[9:0];
      default:        tick_sel = 1'b0;
    endcase
  end

  assign timer_tick = tick_sel;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_nxt;
    end
  end

endmodule : tcw_prescaler

// ---- hdl/tcw_timer.sv ----
`timescale 1ns/1ps

module tcw_timer
  import tcw_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [2:0] clock_select,
  input  wire logic [2:0] waveform_mode,
  input  wire logic [1:0] compare_output_mode_a,
  input  wire logic [1:0] compare_output_mode_b,
  input  wire logic       counter_wr,
  input  wire logic [7:0] counter_wdata,
  input  wire logic       compare_reg_a_wr,
  input  wire logic       compare_reg_b_wr,
  input  wire logic [7:0] compare_wdata,
  input  wire logic       force_compare_strobe_a,
  input  wire logic       force_compare_strobe_b,
  input  wire logic       int_enable_a,
  input  wire logic       int_enable_b,
  input  wire logic       int_enable_ovf,
  input  wire logic       flag_clr_a,
  input  wire logic       flag_clr_b,
  input  wire logic       flag_clr_ovf,
  input  wire logic       int_ack_a,
  input  wire logic       int_ack_b,
  input  wire logic       int_ack_ovf,
  input  wire logic       port_value_a,
  input  wire logic       port_value_b,
  input  wire logic       pin_direction_bit_a,
  input  wire logic       pin_direction_bit_b,
  output logic [7:0]      counter_value,
  output logic [7:0]      compare_reg_a,
  output logic [7:0]      compare_reg_b,
  output logic            compare_flag_a,
  output logic            compare_flag_b,
  output logic            overflow_flag,
  output logic            irq_compare_a,
  output logic            irq_compare_b,
  output logic            irq_overflow,
  output logic            compare_output_a,
  output logic            compare_output_b,
  output logic            pin_out_a,
  output logic            pin_out_b,
  output logic            pin_oe_n_a,
  output logic            pin_oe_n_b
);

  // ==========================================================================
  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ==========================================================================
  // timer tick
  logic timer_tick;

  tcw_prescaler u_pre (
    .clock        (clock),
    .rst_n        (rst_n),
    .clock_select (clock_select),
    .timer_tick   (timer_tick)
  );

  // ==========================================================================
  // mode decode
  typedef enum logic [3:0] {
    TCW_ST_NORMAL = 4'b0001,
    TCW_ST_CLRM   = 4'b0010,
    TCW_ST_FAST   = 4'b0100,
    TCW_ST_PHASE  = 4'b1000
  } tcw_mode_t;

  tcw_mode_t mode;

  always_comb begin
    case (waveform_mode)
      TCW_WGM_NORMAL: mode = TCW_ST_NORMAL;
      TCW_WGM_CLRM:   mode = TCW_ST_CLRM;
      TCW_WGM_FP_FF:  mode = TCW_ST_FAST;
      TCW_WGM_FP_OCA: mode = TCW_ST_FAST;
      TCW_WGM_PC_FF:  mode = TCW_ST_PHASE;
      TCW_WGM_PC_OCA: mode = TCW_ST_PHASE;
      default:        mode = TCW_ST_NORMAL;
    endcase
  end

  // pwm modes count up to top (max, or ocra in the oca modes) and restart at bottom, never down; they also buffer the compare values
  wire is_pwm    = (mode == TCW_ST_FAST) || (mode == TCW_ST_PHASE);
  wire is_clrm   = (mode == TCW_ST_CLRM);
  wire oca_top   = (waveform_mode == TCW_WGM_FP_OCA) || (waveform_mode == TCW_WGM_PC_OCA);

  // ==========================================================================
  // registers
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] ocra_r;
  logic [7:0] ocrb_r;
  logic [7:0] bufa_r;
  logic [7:0] bufb_r;
  logic       block_r;
  logic       flag_a_r;
  logic       flag_b_r;
  logic       flag_ovf_r;
  logic       oc_a_r;
  logic       oc_b_r;
  logic       oc_a_nxt;
  logic       oc_b_nxt;

  // ==========================================================================
  // comparator
  wire match_a_raw = (cnt_r == ocra_r);
  wire match_b_raw = (cnt_r == ocrb_r);

  // a counter write masks matches until a tick has passed
  wire match_a = match_a_raw && !block_r;
  wire match_b = match_b_raw && !block_r;

  wire match_a_tick = timer_tick && match_a;
  wire match_b_tick = timer_tick && match_b;

  // ==========================================================================
  // counter
  wire top_clear = is_clrm && match_a;
  wire at_max    = (cnt_r == TCW_MAX);
  wire top_hit   = oca_top ? (cnt_r == ocra_r) : at_max;

  always_comb begin
    cnt_nxt = cnt_r;
    if (counter_wr) begin
      cnt_nxt = counter_wdata;
    end else if (timer_tick) begin
      if (top_clear) begin
        cnt_nxt = TCW_BOTTOM;
      end else if (is_pwm && top_hit) begin
        cnt_nxt = TCW_BOTTOM;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // overflow on any tick that takes the count from max to zero; a clear-on-match
  // clear below max is not an overflow, one at a top of max is
  wire ovf_event = timer_tick && !counter_wr && at_max;

  // ==========================================================================
  // double buffer: update actives at bottom in pwm modes
  wire at_bottom_tick = timer_tick && (cnt_nxt == TCW_BOTTOM) && !counter_wr;
  wire load_active    = is_pwm && at_bottom_tick;

  // ==========================================================================
  // compare output action, non-pwm table
  function automatic logic tcw_action(input logic [1:0] com, input logic cur);
    case (com)
      TCW_COM_TOGGLE: tcw_action = ~cur;
      TCW_COM_CLEAR:  tcw_action = 1'b0;
      TCW_COM_SET:    tcw_action = 1'b1;
      default:        tcw_action = cur;
    endcase
  endfunction : tcw_action

  wire force_a = force_compare_strobe_a && !is_pwm;
  wire force_b = force_compare_strobe_b && !is_pwm;

  // pwm waveform shaping is not built here; output state just holds there
  always_comb begin
    oc_a_nxt = oc_a_r;
    oc_b_nxt = oc_b_r;
    if (force_a || (match_a_tick && !is_pwm)) begin
      oc_a_nxt = tcw_action(compare_output_mode_a, oc_a_r);
    end
    if (force_b || (match_b_tick && !is_pwm)) begin
      oc_b_nxt = tcw_action(compare_output_mode_b, oc_b_r);
    end
  end

  // ==========================================================================
  // clocked state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= TCW_CNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // block lasts from the write until the next tick has gone by
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      block_r <= 1'b0;
    end else if (counter_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bufa_r <= TCW_CMP_RESET;
      bufb_r <= TCW_CMP_RESET;
    end else begin
      if (compare_reg_a_wr) begin
        bufa_r <= compare_wdata;
      end
      if (compare_reg_b_wr) begin
        bufb_r <= compare_wdata;
      end
    end
  end

  // unbuffered modes write straight through, so a new top acts at once
  wire wr_active_a = compare_reg_a_wr && !is_pwm;
  wire wr_active_b = compare_reg_b_wr && !is_pwm;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ocra_r <= TCW_CMP_RESET;
      ocrb_r <= TCW_CMP_RESET;
    end else begin
      if (wr_active_a) begin
        ocra_r <= compare_wdata;
      end else if (load_active) begin
        ocra_r <= bufa_r;
      end
      if (wr_active_b) begin
        ocrb_r <= compare_wdata;
      end else if (load_active) begin
        ocrb_r <= bufb_r;
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  wire flag_a_nxt   = match_a_tick | (flag_a_r & ~(flag_clr_a | int_ack_a));
  wire flag_b_nxt   = match_b_tick | (flag_b_r & ~(flag_clr_b | int_ack_b));
  wire flag_ovf_nxt = ovf_event | (flag_ovf_r & ~(flag_clr_ovf | int_ack_ovf));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_a_r   <= 1'b0;
      flag_b_r   <= 1'b0;
      flag_ovf_r <= 1'b0;
    end else begin
      flag_a_r   <= flag_a_nxt;
      flag_b_r   <= flag_b_nxt;
      flag_ovf_r <= flag_ovf_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oc_a_r <= 1'b0;
      oc_b_r <= 1'b0;
    end else begin
      oc_a_r <= oc_a_nxt;
      oc_b_r <= oc_b_nxt;
    end
  end

  // ==========================================================================
  // registered outputs and pin stage
  wire ovr_a = |compare_output_mode_a;
  wire ovr_b = |compare_output_mode_b;

  wire [7:0] cmp_rd_a    = is_pwm ? bufa_r : ocra_r;
  wire [7:0] cmp_rd_b    = is_pwm ? bufb_r : ocrb_r;
  wire       irq_a_nxt   = flag_a_r & int_enable_a;
  wire       irq_b_nxt   = flag_b_r & int_enable_b;
  wire       irq_ovf_nxt = flag_ovf_r & int_enable_ovf;
  // the port value keeps the pin whenever the output mode is zero
  wire       pin_a_nxt   = ovr_a ? oc_a_r : port_value_a;
  wire       pin_b_nxt   = ovr_b ? oc_b_r : port_value_b;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counter_value    <= TCW_CNT_RESET;
      compare_reg_a    <= TCW_CMP_RESET;
      compare_reg_b    <= TCW_CMP_RESET;
      compare_flag_a   <= 1'b0;
      compare_flag_b   <= 1'b0;
      overflow_flag    <= 1'b0;
      irq_compare_a    <= 1'b0;
      irq_compare_b    <= 1'b0;
      irq_overflow     <= 1'b0;
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      pin_out_a        <= 1'b0;
      pin_out_b        <= 1'b0;
      pin_oe_n_a       <= 1'b1;
      pin_oe_n_b       <= 1'b1;
    end else begin
      counter_value    <= cnt_r;
      compare_reg_a    <= cmp_rd_a;
      compare_reg_b    <= cmp_rd_b;
      compare_flag_a   <= flag_a_r;
      compare_flag_b   <= flag_b_r;
      overflow_flag    <= flag_ovf_r;
      irq_compare_a    <= irq_a_nxt;
      irq_compare_b    <= irq_b_nxt;
      irq_overflow     <= irq_ovf_nxt;
      compare_output_a <= oc_a_r;
      compare_output_b <= oc_b_r;
      pin_out_a        <= pin_a_nxt;
      pin_out_b        <= pin_b_nxt;
      pin_oe_n_a       <= ~pin_direction_bit_a;
      pin_oe_n_b       <= ~pin_direction_bit_b;
    end
  end

endmodule : tcw_timer

// ---- testbench/tcw_timer_assertions.sv ----
`timescale 1ns/1ps

// ==========
// port checker for the timer top
module tcw_timer_assertions
  import tcw_pkg::*;
(
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic       counter_wr,
  input wire logic [7:0] counter_wdata,
  input wire logic       int_enable_a,
  input wire logic       port_value_a,
  input wire logic       pin_direction_bit_a,
  input wire logic [7:0] counter_value,
  input wire logic [7:0] compare_reg_a,
  input wire logic       compare_flag_a,
  input wire logic       overflow_flag,
  input wire logic       irq_compare_a,
  input wire logic       compare_output_a,
  input wire logic       pin_out_a,
  input wire logic       pin_oe_n_a
);
  logic [2:0] warm_r;
  wire        ok = (warm_r == 3'h7);

  // outputs trail the external release by the reset synchroniser
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) warm_r <= 3'h0;
    else if (!ok) warm_r <= warm_r + 3'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  pin_dir_a: assert property (
    (ok && $past(pin_direction_bit_a) == pin_direction_bit_a
      && $past(pin_direction_bit_a, 2) == pin_direction_bit_a)
    |-> pin_oe_n_a == !pin_direction_bit_a) else $error("pin enable wrong");
  pin_mux_a: assert property (
    (ok && $stable(compare_output_mode_a) && $past(compare_output_mode_a, 2) == compare_output_mode_a
      && $stable(port_value_a) && $past(port_value_a, 2) == port_value_a
      && $stable(compare_output_a) && $past(compare_output_a, 2) == compare_output_a)
    |-> pin_out_a == ((compare_output_mode_a != TCW_COM_NONE) ? compare_output_a : port_value_a))
    else $error("pin source wrong");
  flag_match_a: assert property (
    (ok && $rose(compare_flag_a)) |-> $past(counter_value) == $past(compare_reg_a))
    else $error("flag without match");
  irq_flag_a: assert property (
    (ok && $past(compare_flag_a) == compare_flag_a && $past(compare_flag_a, 2) == compare_flag_a
      && $past(int_enable_a) == int_enable_a && $past(int_enable_a, 2) == int_enable_a)
    |-> irq_compare_a == (compare_flag_a && int_enable_a)) else $error("irq wrong");
  ovf_wrap_a: assert property (
    (ok && $rose(overflow_flag)) |-> counter_value == TCW_BOTTOM
      && $past(counter_value) == TCW_MAX) else $error("overflow without wrap");
  stop_hold_a: assert property (
    (ok && clock_select == TCW_CS_STOP && $past(clock_select) == TCW_CS_STOP
      && $past(clock_select, 2) == TCW_CS_STOP && $past(clock_select, 3) == TCW_CS_STOP
      && !$past(counter_wr) && !$past(counter_wr, 2) && !$past(counter_wr, 3))
    |-> $stable(counter_value)) else $error("counter moved while stopped");
  cnt_load_a: assert property (
    (ok && counter_wr && clock_select == TCW_CS_STOP)
    |-> ##3 counter_value == $past(counter_wdata, 3)) else $error("counter write lost");
  com_none_a: assert property (
    (ok && compare_output_mode_a == TCW_COM_NONE && $past(compare_output_mode_a) == TCW_COM_NONE
      && $past(compare_output_mode_a, 2) == TCW_COM_NONE)
    |-> $stable(compare_output_a)) else $error("output moved with mode none");
endmodule : tcw_timer_assertions

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps

module tb_top
  import tcw_pkg::*;
;
  logic       clock = 1'b0, resetn, counter_wr, compare_reg_a_wr, compare_reg_b_wr;
  logic [2:0] clock_select, waveform_mode;
  logic [1:0] compare_output_mode_a, compare_output_mode_b;
  logic [7:0] counter_wdata, compare_wdata, counter_value, compare_reg_a, compare_reg_b, s, mx;
  logic       force_compare_strobe_a, force_compare_strobe_b, int_enable_a, int_enable_b;
  logic       int_enable_ovf, flag_clr_a, flag_clr_b, flag_clr_ovf, int_ack_a, int_ack_b;
  logic       int_ack_ovf, port_value_a, port_value_b, pin_direction_bit_a, pin_direction_bit_b;
  logic       compare_flag_a, compare_flag_b, overflow_flag, irq_compare_a, irq_compare_b;
  logic       irq_overflow, compare_output_a, compare_output_b, pin_out_a, pin_out_b, prv;
  logic       pin_oe_n_a, pin_oe_n_b;
  int         err_total, checked, n;
  int         dv[7] = '{1, 8, 32, 64, 128, 256, 1024};
  logic [1:0] fm[4] = '{TCW_COM_SET, TCW_COM_CLEAR, TCW_COM_TOGGLE, TCW_COM_NONE};
  logic       fx[4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  tcw_timer u_dut (.clock, .resetn, .clock_select, .waveform_mode, .compare_output_mode_a,
    .compare_output_mode_b, .counter_wr, .counter_wdata, .compare_reg_a_wr, .compare_reg_b_wr,
    .compare_wdata, .force_compare_strobe_a, .force_compare_strobe_b, .int_enable_a,
    .int_enable_b, .int_enable_ovf, .flag_clr_a, .flag_clr_b, .flag_clr_ovf, .int_ack_a,
    .int_ack_b, .int_ack_ovf, .port_value_a, .port_value_b, .pin_direction_bit_a,
    .pin_direction_bit_b, .counter_value, .compare_reg_a, .compare_reg_b, .compare_flag_a,
    .compare_flag_b, .overflow_flag, .irq_compare_a, .irq_compare_b, .irq_overflow,
    .compare_output_a, .compare_output_b, .pin_out_a, .pin_out_b, .pin_oe_n_a, .pin_oe_n_b);

  always #12.5 clock = ~clock;

  // ==========
  // access tasks
  task automatic end_sim();
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    cyc(1);
    sig = 1'b0;
  endtask : pulse
  task automatic wr_cnt(input logic [7:0] d);
    counter_wdata = d;
    pulse(counter_wr);
  endtask : wr_cnt
  task automatic wr_cmp(input logic b, input logic [7:0] d);
    compare_wdata = d;
    if (b) pulse(compare_reg_b_wr);
    else pulse(compare_reg_a_wr);
  endtask : wr_cmp
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_hi(ref logic sig, input int lim);
    for (int i = 0; i < lim && sig !== 1'b1; i++) cyc(1);
    if (sig !== 1'b1) begin
      err_total++;
      $display("[FAIL] wait expected 1 seen %b", sig);
      end_sim();
    end
  endtask : wait_hi
  task automatic stop();
    clock_select = TCW_CS_STOP;
    cyc(4);
  endtask : stop

  // ==========
  // main sequence
  initial begin
    {resetn, counter_wr, compare_reg_a_wr, compare_reg_b_wr, clock_select} = '0;
    {waveform_mode, compare_output_mode_a, compare_output_mode_b, counter_wdata} = '0;
    {compare_wdata, force_compare_strobe_a, force_compare_strobe_b, int_enable_a} = '0;
    {int_enable_b, int_enable_ovf, flag_clr_a, flag_clr_b, flag_clr_ovf, int_ack_a} = '0;
    {int_ack_b, int_ack_ovf, port_value_a, port_value_b, pin_direction_bit_a} = '0;
    {pin_direction_bit_b, err_total, checked} = '0;
    cyc(4);
    resetn = 1'b1;
    cyc(4);
    chk("counter", 8'h00, counter_value);
    chk("oe_n_a", 8'h01, pin_oe_n_a);
    wr_cnt(8'h10);
    cyc(12);
    chk("counter", 8'h10, counter_value);
    wr_cmp(1'b0, 8'h05);
    wr_cmp(1'b1, 8'h08);
    cyc(3);
    chk("cmp_a", 8'h05, compare_reg_a);
    chk("cmp_b", 8'h08, compare_reg_b);
    wr_cnt(8'h00);
    cyc(4);
    int_enable_a = 1'b1;
    clock_select = TCW_CS_DIV1;
    wait_hi(compare_flag_a, 20);
    chk("counter", 8'h06, counter_value);
    cyc(2);
    chk("irq_a", 8'h01, irq_compare_a);
    wait_hi(compare_flag_b, 10);
    chk("counter", 8'h09, counter_value);
    chk("irq_b", 8'h00, irq_compare_b);
    pulse(int_ack_a);
    cyc(3);
    chk("flag_a", 8'h00, compare_flag_a);
    pulse(flag_clr_b);
    cyc(3);
    chk("flag_b", 8'h00, compare_flag_b);
    int_enable_ovf = 1'b1;
    wait_hi(overflow_flag, 300);
    chk("counter", 8'h00, counter_value);
    cyc(5);
    chk("ovf", 8'h01, overflow_flag);
    chk("irq_ovf", 8'h01, irq_overflow);
    pulse(flag_clr_ovf);
    cyc(3);
    chk("ovf", 8'h00, overflow_flag);
    stop();
    pulse(flag_clr_a);
    wr_cnt(8'h05);
    cyc(4);
    clock_select = TCW_CS_DIV1;
    cyc(6);
    chk("flag_a", 8'h00, compare_flag_a);
    for (int i = 0; i < 7; i++) begin
      clock_select = 3'(i + 1);
      cyc(4);
      s = counter_value;
      cyc(dv[i] * 8);
      chk("ticks", 8'h08, 8'(counter_value - s));
    end
    stop();
    wr_cnt(8'h00);
    waveform_mode = TCW_WGM_CLRM;
    wr_cmp(1'b0, 8'h03);
    compare_output_mode_a = TCW_COM_TOGGLE;
    pin_direction_bit_a = 1'b1;
    clock_select = TCW_CS_DIV1;
    cyc(10);
    n = 0;
    mx = 8'h00;
    for (int i = 0; i < 40; i++) begin
      prv = compare_output_a;
      cyc(1);
      if (prv !== compare_output_a) n++;
      if (counter_value > mx) mx = counter_value;
    end
    chk("toggles", 8'd10, 8'(n));
    chk("top", 8'h03, mx);
    chk("oe_n_a", 8'h00, pin_oe_n_a);
    pulse(flag_clr_a);
    cyc(6);
    chk("flag_a", 8'h01, compare_flag_a);
    wr_cnt(8'hf0);
    wait_hi(overflow_flag, 40);
    chk("counter", 8'h00, counter_value);
    stop();
    waveform_mode = TCW_WGM_NORMAL;
    pulse(flag_clr_a);
    s = counter_value;
    for (int i = 0; i < 4; i++) begin
      compare_output_mode_a = fm[i];
      pulse(force_compare_strobe_a);
      cyc(3);
      chk("oc_a", 8'(fx[i]), compare_output_a);
    end
    chk("flag_a", 8'h00, compare_flag_a);
    chk("counter", s, counter_value);
    compare_output_mode_b = TCW_COM_SET;
    pin_direction_bit_b = 1'b1;
    pulse(force_compare_strobe_b);
    cyc(3);
    chk("oc_b", 8'h01, compare_output_b);
    chk("pin_b", 8'h01, pin_out_b);
    chk("oe_n_b", 8'h00, pin_oe_n_b);
    port_value_a = 1'b0;
    cyc(3);
    chk("pin_a", 8'h00, pin_out_a);
    compare_output_mode_a = TCW_COM_CLEAR;
    cyc(3);
    chk("pin_a", 8'h01, pin_out_a);
    waveform_mode = TCW_WGM_FP_FF;
    cyc(3);
    chk("oc_a", 8'h01, compare_output_a);
    pulse(force_compare_strobe_a);
    cyc(3);
    chk("oc_a", 8'h01, compare_output_a);
    pin_direction_bit_a = 1'b0;
    cyc(3);
    chk("oe_n_a", 8'h01, pin_oe_n_a);
    end_sim();
  end
endmodule : tb_top

bind tcw_timer tcw_timer_assertions u_chk (.clock, .resetn, .clock_select,
  .compare_output_mode_a, .counter_wr, .counter_wdata, .int_enable_a, .port_value_a,
  .pin_direction_bit_a, .counter_value, .compare_reg_a, .compare_flag_a, .overflow_flag,
  .irq_compare_a, .compare_output_a, .pin_out_a, .pin_oe_n_a);
